// ==== rtl/adc_cmd_readout.sv ====
// Two-wire slave that decodes command bytes and returns buffered conversion results.
`timescale 1ns/100ps
module adc_cmd_readout
  import adc_cmd_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_out,
  input  wire logic [RESULT_W-1:0] result_in,
  input  wire logic                result_valid_in,
  output logic                     result_ready_out,
  output setup_t                   setup_out,
  output config_t                  config_out,
  output route_t                   route_out
);
  localparam int PTR_W = $clog2(DEPTH);

  // ---------------------------------------------------------------------------
  // Line sampling and bus conditions
  // ---------------------------------------------------------------------------
  logic scl_s, sda_s, scl_d_ff, sda_d_ff;

  sync2 #(.WIDTH(1)) u_scl_sync (.clk_in(clk_in), .rst_in(rst_in), .d_in(scl_in), .q_out(scl_s));
  sync2 #(.WIDTH(1)) u_sda_sync (.clk_in(clk_in), .rst_in(rst_in), .d_in(sda_in), .q_out(sda_s));

  wire scl_rise  = scl_s & ~scl_d_ff;
  wire scl_fall  = ~scl_s & scl_d_ff;
  wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ---------------------------------------------------------------------------
  // Two-entry result buffer
  // ---------------------------------------------------------------------------
  logic [RESULT_W-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0]    wr_ptr_ff, rd_ptr_ff;
  logic [PTR_W:0]      count_ff;
  logic                load;
  logic                sel_ff;

  wire                buf_full  = (count_ff == (PTR_W+1)'(DEPTH));
  wire                buf_empty = (count_ff == '0);
  wire                push      = result_valid_in & ~buf_full;
  wire                pop       = load & ~sel_ff & ~buf_empty;
  wire [RESULT_W-1:0] head      = mem_ff[rd_ptr_ff];

  assign result_ready_out = ~buf_full;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= result_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= push ? PTR_W'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
      rd_ptr_ff <= pop  ? PTR_W'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
      count_ff  <= (PTR_W+1)'(count_ff + push - pop);
    end
  end

  // ---------------------------------------------------------------------------
  // Link state machine
  // ---------------------------------------------------------------------------
  link_state_t         state_ff, nxt_state;
  logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
  logic [BYTE_W-1:0]   shift_ff, nxt_shift;
  logic                oe_ff, nxt_oe, rw_ff, nxt_rw, nack_ff, nxt_nack, nxt_sel;
  logic [RESULT_W-1:0] word_ff, nxt_word;
  setup_t              setup_ff, nxt_setup;
  config_t             cfg_ff, nxt_cfg;
  route_t              route_ff, nxt_route;

  wire byte_in   = (cnt_ff == CNT_W'(BYTE_W));
  wire addr_hit  = (shift_ff[BYTE_W-1:1] == DEV_ADDR);
  wire is_setup  = shift_ff[REG_BIT];
  wire cfg_reset = ~shift_ff[RST_BIT];
  wire last_bit  = (cnt_ff == CNT_W'(BYTE_W-1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_shift = shift_ff;
    nxt_oe    = oe_ff;
    nxt_rw    = rw_ff;
    nxt_nack  = nack_ff;
    nxt_sel   = sel_ff;
    nxt_word  = word_ff;
    nxt_setup = setup_ff;
    nxt_cfg   = cfg_ff;
    load      = 1'b0;
    if (stop_det) begin
      nxt_state = ST_IDLE;
      nxt_oe    = 1'b0;
    end else if (start_det) begin
      nxt_state = ST_ADDR;
      nxt_cnt   = '0;
      nxt_oe    = 1'b0;
      nxt_sel   = 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[BYTE_W-2:0], sda_s};
            nxt_cnt   = CNT_W'(cnt_ff + 1'b1);
          end else if (scl_fall && byte_in) begin
            nxt_rw    = shift_ff[0];
            nxt_state = addr_hit ? ST_ADDR_ACK : ST_IDLE;
            nxt_oe    = addr_hit;
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[BYTE_W-2:0], sda_s};
            nxt_cnt   = CNT_W'(cnt_ff + 1'b1);
          end else if (scl_fall && byte_in) begin
            if (is_setup) begin
              nxt_setup.ref_select      = shift_ff[SEL_HI:SEL_LO];
              nxt_setup.clock_ext       = shift_ff[CLK_BIT];
              nxt_setup.polarity_select = shift_ff[POL_BIT];
              if (cfg_reset) begin
                nxt_cfg = CONFIG_RESET;
              end
            end else begin
              nxt_cfg.scan_select       = shift_ff[SCAN_HI:SCAN_LO];
              nxt_cfg.channel_select    = shift_ff[CS_BIT];
              nxt_cfg.input_type_select = shift_ff[SGL_BIT];
            end
            nxt_state = ST_WR_ACK;
            nxt_oe    = 1'b1;
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            nxt_oe  = 1'b0;
            nxt_cnt = '0;
            if (state_ff == ST_ADDR_ACK && rw_ff) begin
              nxt_state = ST_RD;
              load      = 1'b1;
            end else begin
              nxt_state = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (last_bit) begin
              nxt_state = ST_RD_ACK;
              nxt_oe    = 1'b0;
            end else begin
              nxt_shift = {shift_ff[BYTE_W-2:0], 1'b1};
              nxt_oe    = ~shift_ff[BYTE_W-2];
              nxt_cnt   = CNT_W'(cnt_ff + 1'b1);
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nxt_nack = sda_s;
          end else if (scl_fall) begin
            nxt_cnt   = '0;
            nxt_state = nack_ff ? ST_IDLE : ST_RD;
            load      = ~nack_ff;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_oe    = 1'b0;
        end
      endcase
    end
    // The first byte of a result takes a fresh word; with the buffer empty the
    // previous word is sent again rather than stalling the bus.
    if (load) begin
      if (!sel_ff) begin
        nxt_word  = buf_empty ? word_ff : head;
        nxt_shift = {{PAD_W{1'b1}}, nxt_word[RESULT_W-1:BYTE_W]};
      end else begin
        nxt_shift = word_ff[BYTE_W-1:0];
      end
      nxt_sel = ~sel_ff;
      nxt_oe  = ~nxt_shift[BYTE_W-1];
    end
  end

  always_comb begin
    nxt_route.pos = cfg_ff.channel_select ? SRC_B : SRC_A;
    nxt_route.neg = cfg_ff.input_type_select ? SRC_GND :
                    (cfg_ff.channel_select ? SRC_A : SRC_B);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      shift_ff <= '0;
      oe_ff    <= 1'b0;
      rw_ff    <= 1'b0;
      nack_ff  <= 1'b0;
      sel_ff   <= 1'b0;
      word_ff  <= '0;
      setup_ff <= SETUP_RESET;
      cfg_ff   <= CONFIG_RESET;
      route_ff <= ROUTE_RESET;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      shift_ff <= nxt_shift;
      oe_ff    <= nxt_oe;
      rw_ff    <= nxt_rw;
      nack_ff  <= nxt_nack;
      sel_ff   <= nxt_sel;
      word_ff  <= nxt_word;
      setup_ff <= nxt_setup;
      cfg_ff   <= nxt_cfg;
      route_ff <= nxt_route;
    end
  end

  // Open drain: only ever pulls low.
  assign sda_out    = 1'b0;
  assign sda_oe_out = oe_ff;
  assign setup_out  = setup_ff;
  assign config_out = cfg_ff;
  assign route_out  = route_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  wire wr_done = (state_ff == ST_WR) & scl_fall & byte_in & ~start_det & ~stop_det;

  sequence s_setup_byte;
    wr_done && is_setup;
  endsequence

  sequence s_addr_done;
    (state_ff == ST_ADDR) && scl_fall && byte_in && !start_det && !stop_det;
  endsequence

  property p_setup_load;
    s_setup_byte |=> setup_ff == {$past(shift_ff[SEL_HI:CLK_BIT]), $past(shift_ff[POL_BIT])};
  endproperty
  a_setup_load: assert property (p_setup_load) else $error("setup byte not loaded");
  property p_cfg_default;
    s_setup_byte ##0 cfg_reset |=> cfg_ff == CONFIG_RESET;
  endproperty
  a_cfg_default: assert property (p_cfg_default) else $error("config not defaulted");
  property p_cfg_keep;
    s_setup_byte ##0 !cfg_reset |=> $stable(cfg_ff);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("config changed on setup");
  property p_cfg_load;
    wr_done && !is_setup |=> cfg_ff == {$past(shift_ff[SCAN_HI:SCAN_LO]),
                                        $past(shift_ff[CS_BIT:SGL_BIT])} && $stable(setup_ff);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config byte not loaded");
  property p_addr_ack;
    s_addr_done ##0 addr_hit |=> sda_oe_out && state_ff == ST_ADDR_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
  property p_addr_miss;
    s_addr_done ##0 !addr_hit |=> !sda_oe_out && state_ff == ST_IDLE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");
  property p_pad_high;
    state_ff == ST_RD && sel_ff && cnt_ff < CNT_W'(PAD_W) |-> !sda_oe_out;
  endproperty
  a_pad_high: assert property (p_pad_high) else $error("pad bit driven low");
  property p_nack_release;
    state_ff == ST_RD_ACK && nack_ff && scl_fall && !start_det && !stop_det
      |=> state_ff == ST_IDLE ##1 !sda_oe_out [*2];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("data line held after nack");
  property p_route;
    ##1 route_out.pos == ($past(cfg_ff.channel_select) ? SRC_B : SRC_A) &&
        ($past(cfg_ff.input_type_select) ? route_out.neg == SRC_GND
                                          : route_out.neg != route_out.pos);
  endproperty
  a_route: assert property (p_route) else $error("input routing wrong");

endmodule : adc_cmd_readout

// ==== rtl/adc_cmd_pkg.sv ====
// Constants, field layouts and types for the converter command and readout front end.
// Overview of operation
// - Bit 7 of a written byte picks setup (one) or configuration (zero).
// - Setup bit 2 picks bipolar (one) or unipolar; zero after reset.
// - Setup bit 1 at zero restores configuration defaults; setup itself keeps new value.
// - Setup bit 0 is ignored.
// - Configuration bits 6..5 load scan select; zero after reset.
// - Configuration bit 0 picks single-ended (one) or differential; one after reset.
// - Single-ended: channel select 0 converts input a, 1 input b, against ground.
// - Master starts reads with START, address and read bit; device acknowledges address.
// - Each result goes out as two bytes: six high bits, then result MSB first.
// - Write carries one or two command bytes, any order; each is acknowledged.
// - Device answers only address 0110110; address LSB zero writes, one reads.
// - Differential: channel select 0 makes a positive, b negative; 1 reverses.
// - On a master not-acknowledge the device releases the data line.
package adc_cmd_pkg;

  localparam logic [6:0] DEV_ADDR   = 7'h36;
  localparam int         BYTE_W     = 8;
  localparam int         RESULT_W   = 10;
  localparam int         PAD_W      = 6;
  localparam int         CNT_W      = 4;

  // Setup byte fields.
  localparam int         REG_BIT    = 7;
  localparam int         SEL_HI     = 6;
  localparam int         SEL_LO     = 4;
  localparam int         CLK_BIT    = 3;
  localparam int         POL_BIT    = 2;
  localparam int         RST_BIT    = 1;
  // Configuration byte fields.
  localparam int         SCAN_HI    = 6;
  localparam int         SCAN_LO    = 5;
  localparam int         CS_BIT     = 1;
  localparam int         SGL_BIT    = 0;

  typedef struct packed {
    logic [2:0] ref_select;
    logic       clock_ext;
    logic       polarity_select;
  } setup_t;

  typedef struct packed {
    logic [1:0] scan_select;
    logic       channel_select;
    logic       input_type_select;
  } config_t;

  localparam setup_t  SETUP_RESET  = '{ref_select: 3'h0, clock_ext: 1'b0, polarity_select: 1'b0};
  localparam config_t CONFIG_RESET = '{scan_select: 2'h0, channel_select: 1'b0,
                                       input_type_select: 1'b1};

  typedef enum logic [1:0] {
    SRC_GND = 2'h0,
    SRC_A   = 2'h1,
    SRC_B   = 2'h2
  } src_t;

  typedef struct packed {
    src_t pos;
    src_t neg;
  } route_t;

  localparam route_t ROUTE_RESET = '{pos: SRC_A, neg: SRC_GND};

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR       = 7'h08,
    ST_WR_ACK   = 7'h10,
    ST_RD       = 7'h20,
    ST_RD_ACK   = 7'h40
  } link_state_t;

endpackage : adc_cmd_pkg

// ==== rtl/sync2.sv ====
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;

  // Bus lines idle high, so both stages reset to one to avoid a false START.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= '1;
      q_out   <= '1;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end
endmodule : sync2

// ==== test/adc_i2c_master_model.sv ====
// Behavioural two-wire bus master that drives the clock line and pulls the data line low.
`timescale 1ns/100ps
module adc_i2c_master_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // ------------------------------------------------------------------
  // Idle bus
  // ------------------------------------------------------------------
  // The clock stands high between frames, and data is only ever pulled low, so a
  // released line shows the pull-up level rather than the last driven value.
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_clk

  // ------------------------------------------------------------------
  // Bus conditions
  // ------------------------------------------------------------------
  task automatic start_cond;
    wait_clk(2);
    sda_oe_out = 1'b0;
    wait_clk(2);
    scl_out = 1'b1;
    wait_clk(4);
    sda_oe_out = 1'b1;
    wait_clk(4);
    scl_out = 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    wait_clk(2);
    sda_oe_out = 1'b1;
    wait_clk(2);
    scl_out = 1'b1;
    wait_clk(4);
    sda_oe_out = 1'b0;
    wait_clk(4);
  endtask : stop_cond

  // Data changes only in the middle of the low phase and is sampled mid-high.
  task automatic one_bit(input logic b, output logic s);
    wait_clk(2);
    sda_oe_out = ~b;
    wait_clk(2);
    scl_out = 1'b1;
    wait_clk(2);
    s = sda_in;
    wait_clk(2);
    scl_out = 1'b0;
  endtask : one_bit

  // ------------------------------------------------------------------
  // Byte transfers
  // ------------------------------------------------------------------
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(b[i], s);
    end
    one_bit(1'b1, s);
    ack = ~s;
  endtask : write_byte

  task automatic read_byte(input logic stop_rd, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(1'b1, s);
      d[i] = s;
    end
    one_bit(stop_rd, s);
  endtask : read_byte
endmodule : adc_i2c_master_model

// ==== test/tb_adc_cmd_readout.sv ====
// Self-checking testbench for the converter command and readout front end.
`timescale 1ns/100ps
module tb_adc_cmd_readout;
  import adc_cmd_pkg::*;

  logic                clk_in;
  logic                rst_in;
  logic                scl;
  logic                m_oe;
  logic                sda_line;
  logic                sda_out;
  logic                sda_oe_out;
  logic [RESULT_W-1:0] result_in;
  logic                result_valid_in;
  logic                result_ready_out;
  setup_t              setup_out;
  config_t             config_out;
  route_t              route_out;
  int                  failures;
  int                  total_checks;
  logic                ack;
  logic [7:0]          d;
  logic [7:0]          cfg_byte [4] = '{8'h7e, 8'h21, 8'h1f, 8'h40};
  logic [3:0]          cfg_exp  [4] = '{4'he, 4'h5, 4'h3, 4'h8};
  logic [3:0]          rte_exp  [4] = '{4'h9, 4'h4, 4'h8, 4'h6};

  // Open-drain data line with pull-up: low whenever either party pulls it.
  assign sda_line = ((sda_oe_out && !sda_out) || m_oe) ? 1'b0 : 1'b1;

  adc_cmd_readout u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .result_in(result_in),
    .result_valid_in(result_valid_in), .result_ready_out(result_ready_out),
    .setup_out(setup_out), .config_out(config_out), .route_out(route_out)
  );

  adc_i2c_master_model u_m (
    .clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(m_oe)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic close_out;
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] b0, input logic [7:0] b1, input int n);
    u_m.start_cond();
    u_m.write_byte({DEV_ADDR, 1'b0}, ack);
    check("write address ack", ack, 1'b1);
    u_m.write_byte(b0, ack);
    check("first byte ack", ack, 1'b1);
    if (n == 2) begin
      u_m.write_byte(b1, ack);
      check("second byte ack", ack, 1'b1);
    end
    u_m.stop_cond();
  endtask : wr

  task automatic push(input logic [RESULT_W-1:0] w);
    int n;
    result_in       = w;
    result_valid_in = 1'b1;
    n = 0;
    while (result_ready_out !== 1'b1 && n < 50) begin
      u_m.wait_clk(1);
      n++;
    end
    if (n >= 50) begin
      failures++;
      close_out();
    end
    u_m.wait_clk(1);
    result_valid_in = 1'b0;
    // Let an edge pass so a following call never raises valid in the same step.
    u_m.wait_clk(1);
  endtask : push

  // ------------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    close_out();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    failures        = 0;
    total_checks    = 0;
    rst_in          = 1'b1;
    result_in       = 10'h000;
    result_valid_in = 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    check("setup reset", setup_out, 5'h00);
    check("config reset", config_out, 4'h1);
    u_m.wait_clk(3);
    check("route reset", route_out, 4'h4);
    // A foreign address must be ignored, along with the byte that follows it.
    u_m.start_cond();
    u_m.write_byte({7'h37, 1'b0}, ack);
    check("foreign address ack", ack, 1'b0);
    u_m.write_byte(8'hfe, ack);
    u_m.stop_cond();
    check("setup after foreign", setup_out, 5'h00);
    wr(8'hdf, 8'h00, 1);
    check("setup load", setup_out, 5'h17);
    check("config kept", config_out, 4'h1);
    wr(8'hde, 8'h00, 1);
    check("setup ignores bit0", setup_out, 5'h17);
    for (int i = 0; i < 4; i++) begin
      wr(cfg_byte[i], 8'h00, 1);
      check("config load", config_out, cfg_exp[i]);
      check("route select", route_out, rte_exp[i]);
      check("setup kept", setup_out, 5'h17);
    end
    // Configuration then a setup byte whose bit 1 is zero, in one transaction.
    wr(8'h7e, 8'h9d, 2);
    check("config defaults", config_out, 4'h1);
    check("setup new value", setup_out, 5'h07);
    check("route defaults", route_out, 4'h4);
    // Fill the two-entry buffer, then read both words back.
    push(10'h2a5);
    push(10'h15a);
    u_m.wait_clk(1);
    check("buffer full", result_ready_out, 1'b0);
    u_m.start_cond();
    u_m.write_byte({DEV_ADDR, 1'b1}, ack);
    check("read address ack", ack, 1'b1);
    u_m.read_byte(1'b0, d);
    check("word0 byte0", d, 8'hfe);
    u_m.read_byte(1'b0, d);
    check("word0 byte1", d, 8'ha5);
    u_m.read_byte(1'b0, d);
    check("word1 byte0", d, 8'hfd);
    u_m.read_byte(1'b1, d);
    check("word1 byte1", d, 8'h5a);
    u_m.wait_clk(6);
    check("data released", sda_oe_out, 1'b0);
    u_m.stop_cond();
    check("buffer drained", result_ready_out, 1'b1);
    // Empty buffer: the last word goes out again rather than stalling the bus.
    u_m.start_cond();
    u_m.write_byte({DEV_ADDR, 1'b1}, ack);
    check("reread address ack", ack, 1'b1);
    u_m.read_byte(1'b0, d);
    check("stale byte0", d, 8'hfd);
    u_m.read_byte(1'b1, d);
    check("stale byte1", d, 8'h5a);
    u_m.stop_cond();
    // A reset in mid-run must restore every register default.
    wr(8'h7e, 8'h00, 1);
    rst_in = 1'b1;
    u_m.wait_clk(2);
    rst_in = 1'b0;
    check("setup mid reset", setup_out, 5'h00);
    check("config mid reset", config_out, 4'h1);
    u_m.wait_clk(3);
    check("route mid reset", route_out, 4'h4);
    close_out();
  end
endmodule : tb_adc_cmd_readout
